// *** psm_pkg.sv ***
package psm_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] CTRL_IDX = 8'h87;
	localparam logic [7:0] STAT_IDX = 8'h88;
	localparam int ADDR_W = 12;

	// power control register field positions
	localparam int IDLE_ARM_POS = 0;
	localparam int HALT_ARM_POS = 1;
	localparam int GF0_POS = 2;
	localparam int GF1_POS = 3;
	localparam int SLEEP_GO_POS = 5;
	localparam int HALT_GO_POS = 6;
	localparam int SMOD_POS = 7;

	// status register field positions
	localparam int ST_IDLE_POS = 0;
	localparam int ST_HALT_POS = 1;
	localparam int ST_IARM_POS = 2;
	localparam int ST_HARM_POS = 3;
	localparam int ST_PEN_POS = 4;

	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h00000000;

	typedef enum logic [1:0] {
		PSM_ACTIVE,
		PSM_IDLE,
		PSM_HALT
	} psm_mode_t;

endpackage

// *** psm_power_ctrl.sv ***
// Function
// - core and watchdog clocks stop during idle
// - modes enter only with enable pin low
// - arm and start together never enter idle
// - idle arm/start self clear, read zero
// - idle start write is last core instruction
// - enabled interrupt ends idle
// - hardware reset ends idle
// - power-down stops oscillator, keeps state
// - power-down holds port and alternate outputs
// - clock output stops low in power-down
// - strobes held low in power-down
// - arm and start together never power down
// - power-down arm/start self clear, read zero
// - power-down start write is last instruction
// - only hardware reset leaves power-down
// - leaving reset restarts the oscillator
// - idle gates only core and watchdog clocks
// - both requested at once: power-down wins
// - strobes held high in idle
//
// Implementation choices: the APB register port and the address map.
module psm_power_ctrl #(
	parameter int ALT_W = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [psm_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core side
	input wire logic power_save_enable_pin_n,
	input wire logic instr_retire,
	input wire logic irq_pending,
	input wire logic core_ale,
	input wire logic core_program_store_strobe,
	input wire logic clock_output_enable,
	input wire logic clock_output_src,
	input wire logic [ALT_W-1:0] alt_out_in,
	// clock gating
	output logic osc_en,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic wdt_clk_en,
	// pins and status
	output logic ale,
	output logic program_store_strobe,
	output logic clock_output_pin,
	output logic [ALT_W-1:0] alt_out,
	output logic baud_double,
	output logic in_idle,
	output logic in_power_down
);

	typedef struct packed {
		psm_pkg::psm_mode_t mode;
		logic idle_arm;
		logic halt_arm;
		logic gf0;
		logic gf1;
		logic smod;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic osc;
		logic cpu_en;
		logic per_en;
		logic wdt_en;
		logic ale;
		logic pss;
		logic ckout;
		logic [ALT_W-1:0] alt;
		logic idle;
		logic halt;
	} psm_state_t;

	psm_state_t state_reg;
	psm_state_t state_next;

	function automatic logic idx_hit(
		input logic [psm_pkg::ADDR_W-1:0] addr,
		input logic [7:0] idx
	);
		logic [psm_pkg::ADDR_W-1:0] byte_addr;
		byte_addr = {{(psm_pkg::ADDR_W-10){1'b0}}, idx, 2'b00};
		return addr == byte_addr;
	endfunction

	logic access;
	logic wait_cycle;
	logic wr;
	logic hit_ctrl;
	logic hit_stat;
	logic save_ok;
	logic w_iarm;
	logic w_igo;
	logic w_harm;
	logic w_hgo;
	logic go_idle;
	logic go_halt;
	logic [7:0] ctrl_rd;
	logic [7:0] stat_rd;

	always_comb begin
		wait_cycle = psel & penable & ~state_reg.ready;
		access = psel & penable & state_reg.ready;
		wr = access & pwrite;
		hit_ctrl = idx_hit(paddr, psm_pkg::CTRL_IDX);
		hit_stat = idx_hit(paddr, psm_pkg::STAT_IDX);
		// the pin gates only the start write; an arm is still recorded
		save_ok = ~power_save_enable_pin_n;
		w_iarm = pwdata[psm_pkg::IDLE_ARM_POS];
		w_igo = pwdata[psm_pkg::SLEEP_GO_POS];
		w_harm = pwdata[psm_pkg::HALT_ARM_POS];
		w_hgo = pwdata[psm_pkg::HALT_GO_POS];
		// a start write only counts when the arm was set by the
		// previous instruction and this write leaves the arm clear
		go_idle = wr & hit_ctrl & save_ok & state_reg.idle_arm &
			w_igo & ~w_iarm;
		go_halt = wr & hit_ctrl & save_ok & state_reg.halt_arm &
			w_hgo & ~w_harm;
		// arm and start bits always read zero in the control byte
		ctrl_rd = 8'h00;
		ctrl_rd[psm_pkg::SMOD_POS] = state_reg.smod;
		ctrl_rd[psm_pkg::GF1_POS] = state_reg.gf1;
		ctrl_rd[psm_pkg::GF0_POS] = state_reg.gf0;
		// the status byte shows the mode and any pending arm
		stat_rd = 8'h00;
		stat_rd[psm_pkg::ST_IDLE_POS] = state_reg.idle;
		stat_rd[psm_pkg::ST_HALT_POS] = state_reg.halt;
		stat_rd[psm_pkg::ST_IARM_POS] = state_reg.idle_arm;
		stat_rd[psm_pkg::ST_HARM_POS] = state_reg.halt_arm;
		stat_rd[psm_pkg::ST_PEN_POS] = save_ok;
	end

	always_comb begin
		state_next = state_reg;

		// apb: one wait state, answer registered, so no path runs
		// combinationally from the bus inputs to prdata
		state_next.ready = wait_cycle;
		state_next.slverr = 1'b0;
		if (wait_cycle) begin
			// unmapped offsets answer with an error and read zero
			state_next.slverr = ~(hit_ctrl | hit_stat);
			state_next.rdata = psm_pkg::RDATA_RST;
			if (~pwrite & hit_ctrl) begin
				state_next.rdata = {24'h000000, ctrl_rd};
			end
			if (~pwrite & hit_stat) begin
				state_next.rdata = {24'h000000, stat_rd};
			end
		end

		// an arm survives only until the next instruction retires
		if (instr_retire | wr) begin
			state_next.idle_arm = 1'b0;
			state_next.halt_arm = 1'b0;
		end

		// flag and baud bits are plain storage, written in any mode
		if (wr & hit_ctrl) begin
			state_next.smod = pwdata[psm_pkg::SMOD_POS];
			state_next.gf1 = pwdata[psm_pkg::GF1_POS];
			state_next.gf0 = pwdata[psm_pkg::GF0_POS];
			// a write that sets arm and start together arms nothing
			state_next.idle_arm = w_iarm & ~w_igo;
			state_next.halt_arm = w_harm & ~w_hgo;
		end

		case (state_reg.mode)
			psm_pkg::PSM_ACTIVE: begin
				if (go_halt) begin
					state_next.mode = psm_pkg::PSM_HALT;
				end else if (go_idle) begin
					state_next.mode = psm_pkg::PSM_IDLE;
				end
			end
			psm_pkg::PSM_IDLE: begin
				// core resumes after the start write on return
				if (irq_pending) begin
					state_next.mode = psm_pkg::PSM_ACTIVE;
				end
			end
			psm_pkg::PSM_HALT: begin
				// no interrupt can wake: the oscillator is stopped
				state_next.mode = psm_pkg::PSM_HALT;
			end
			default: begin
				state_next.mode = psm_pkg::PSM_ACTIVE;
			end
		endcase
		if (state_next.mode != psm_pkg::PSM_ACTIVE) begin
			state_next.idle_arm = 1'b0;
			state_next.halt_arm = 1'b0;
		end

		// status flags are registered so the mode outputs carry no
		// decode logic after the flops
		state_next.idle = state_next.mode == psm_pkg::PSM_IDLE;
		state_next.halt = state_next.mode == psm_pkg::PSM_HALT;

		// gating follows the next mode so the start write is the
		// final instruction the core completes
		case (state_next.mode)
			psm_pkg::PSM_ACTIVE: begin
				state_next.osc = 1'b1;
				state_next.cpu_en = 1'b1;
				state_next.per_en = 1'b1;
				state_next.wdt_en = 1'b1;
				state_next.ale = core_ale;
				state_next.pss = core_program_store_strobe;
				state_next.ckout = clock_output_enable & clock_output_src;
				state_next.alt = alt_out_in;
			end
			psm_pkg::PSM_IDLE: begin
				state_next.osc = 1'b1;
				state_next.cpu_en = 1'b0;
				state_next.per_en = 1'b1;
				state_next.wdt_en = 1'b0;
				state_next.ale = 1'b1;
				state_next.pss = 1'b1;
				// alternate functions keep running in idle
				state_next.ckout = clock_output_enable & clock_output_src;
				state_next.alt = alt_out_in;
			end
			psm_pkg::PSM_HALT: begin
				state_next.osc = 1'b0;
				state_next.cpu_en = 1'b0;
				state_next.per_en = 1'b0;
				state_next.wdt_en = 1'b0;
				state_next.ale = 1'b0;
				state_next.pss = 1'b0;
				state_next.ckout = 1'b0;
				// hold the value from the entering instruction
				state_next.alt = state_reg.alt;
			end
			default: begin
				state_next.osc = 1'b1;
				state_next.cpu_en = 1'b1;
				state_next.per_en = 1'b1;
				state_next.wdt_en = 1'b1;
				state_next.ale = core_ale;
				state_next.pss = core_program_store_strobe;
				state_next.ckout = 1'b0;
				state_next.alt = alt_out_in;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			// reset ends either mode and restarts the oscillator;
			// exit timing is left to whoever holds the reset
			state_reg.mode <= psm_pkg::PSM_ACTIVE;
			state_reg.idle <= 1'b0;
			state_reg.halt <= 1'b0;
			// control bits go back to their reset value
			state_reg.idle_arm <= psm_pkg::CTRL_RST[psm_pkg::IDLE_ARM_POS];
			state_reg.halt_arm <= psm_pkg::CTRL_RST[psm_pkg::HALT_ARM_POS];
			state_reg.gf0 <= psm_pkg::CTRL_RST[psm_pkg::GF0_POS];
			state_reg.gf1 <= psm_pkg::CTRL_RST[psm_pkg::GF1_POS];
			state_reg.smod <= psm_pkg::CTRL_RST[psm_pkg::SMOD_POS];
			state_reg.rdata <= psm_pkg::RDATA_RST;
			state_reg.ready <= 1'b0;
			state_reg.slverr <= 1'b0;
			state_reg.osc <= 1'b1;
			state_reg.cpu_en <= 1'b1;
			state_reg.per_en <= 1'b1;
			state_reg.wdt_en <= 1'b1;
			state_reg.ale <= 1'b0;
			state_reg.pss <= 1'b0;
			state_reg.ckout <= 1'b0;
			state_reg.alt <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// every output is a register bit with no logic after it
	assign prdata = state_reg.rdata;
	assign pready = state_reg.ready;
	assign pslverr = state_reg.slverr;
	assign osc_en = state_reg.osc;
	assign cpu_clk_en = state_reg.cpu_en;
	assign periph_clk_en = state_reg.per_en;
	assign wdt_clk_en = state_reg.wdt_en;
	assign ale = state_reg.ale;
	assign program_store_strobe = state_reg.pss;
	assign clock_output_pin = state_reg.ckout;
	assign alt_out = state_reg.alt;
	assign baud_double = state_reg.smod;
	assign in_idle = state_reg.idle;
	assign in_power_down = state_reg.halt;

endmodule

// *** psm_power_ctrl_chk.sv ***
module psm_ctrl_chk #(
	parameter int ALT_W = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// pins and mode state
	input wire logic power_save_enable_pin_n,
	input wire logic irq_pending,
	input wire logic osc_en,
	input wire logic cpu_clk_en,
	input wire logic wdt_clk_en,
	input wire logic ale,
	input wire logic program_store_strobe,
	input wire logic clock_output_pin,
	input wire logic [ALT_W-1:0] alt_out,
	input wire logic in_idle,
	input wire logic in_power_down
);
	timeunit 1ns / 100ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence wake_idle;
		in_idle && irq_pending;
	endsequence
	chk_idle_gates: assert property (in_idle |->
		osc_en && !cpu_clk_en && !wdt_clk_en) else $error("idle gate");
	chk_pd_stops: assert property (in_power_down |->
		!osc_en && !cpu_clk_en) else $error("pd clocks");
	chk_idle_strobes: assert property (in_idle |->
		ale && program_store_strobe) else $error("idle strobes");
	chk_pd_pins: assert property (in_power_down |->
		!ale && !program_store_strobe && !clock_output_pin) else $error("pd pins");
	chk_pd_alt_hold: assert property (in_power_down && $past(in_power_down)
		|-> $stable(alt_out)) else $error("pd alt moved");
	chk_pd_stays: assert property (in_power_down |=>
		in_power_down) else $error("pd left");
	chk_idle_wake: assert property (wake_idle |=>
		!in_idle && cpu_clk_en && wdt_clk_en) else $error("no wake");
	chk_pin_blocks: assert property (power_save_enable_pin_n &&
		!in_idle && !in_power_down |=> !in_idle && !in_power_down)
		else $error("pin ignored");
endmodule

bind psm_power_ctrl psm_ctrl_chk #(.ALT_W(ALT_W)) chk_u (
	.clock(clock), .rst_b(rst_b),
	.power_save_enable_pin_n(power_save_enable_pin_n),
	.irq_pending(irq_pending), .osc_en(osc_en), .cpu_clk_en(cpu_clk_en),
	.wdt_clk_en(wdt_clk_en), .ale(ale),
	.program_store_strobe(program_store_strobe),
	.clock_output_pin(clock_output_pin), .alt_out(alt_out),
	.in_idle(in_idle), .in_power_down(in_power_down)
);

// *** psm_core_model.sv ***
module psm_core_model (
	// clock, reset and requests
	input wire logic clock,
	input wire logic rst_b,
	input wire logic wake,
	input wire logic retire_req,
	input wire logic cpu_clk_en,
	// core outputs
	output logic instr_retire,
	output logic irq_pending,
	output logic core_ale,
	output logic core_program_store_strobe
);
	timeunit 1ns / 100ps;
	// a gated core retires nothing and its strobes stop
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			{instr_retire, irq_pending} <= '0;
			{core_ale, core_program_store_strobe} <= '0;
		end else begin
			instr_retire <= retire_req && cpu_clk_en;
			irq_pending <= wake;
			core_ale <= cpu_clk_en && !core_ale;
			core_program_store_strobe <= core_ale;
		end
	end
endmodule

// *** psm_testbench.sv ***
module testbench;
	timeunit 1ns / 100ps;
	localparam logic [11:0] PA = {2'h0, psm_pkg::CTRL_IDX, 2'h0};
	logic clock = '0, rst_b = '0, psel = '0, penable = '0, pwrite = '0;
	logic wake = '0, retire_req = '0;
	logic clock_output_enable = '1, clock_output_src = '1;
	logic power_save_enable_pin_n = '0, pready, pslverr, instr_retire, se;
	logic irq_pending, core_ale, core_program_store_strobe, osc_en;
	logic cpu_clk_en, periph_clk_en, wdt_clk_en, ale, program_store_strobe;
	logic clock_output_pin, baud_double, in_idle, in_power_down;
	logic [psm_pkg::ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [7:0] alt_out_in = 8'ha5, alt_out;
	int err_count = 0, samples_checked = 0;
	psm_power_ctrl dut_u (
		.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.power_save_enable_pin_n(power_save_enable_pin_n),
		.instr_retire(instr_retire), .irq_pending(irq_pending),
		.core_ale(core_ale),
		.core_program_store_strobe(core_program_store_strobe),
		.clock_output_enable(clock_output_enable),
		.clock_output_src(clock_output_src), .alt_out_in(alt_out_in),
		.osc_en(osc_en), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .wdt_clk_en(wdt_clk_en), .ale(ale),
		.program_store_strobe(program_store_strobe),
		.clock_output_pin(clock_output_pin), .alt_out(alt_out),
		.baud_double(baud_double), .in_idle(in_idle),
		.in_power_down(in_power_down)
	);
	psm_core_model core_u (
		.clock(clock), .rst_b(rst_b), .wake(wake), .retire_req(retire_req),
		.cpu_clk_en(cpu_clk_en), .instr_retire(instr_retire),
		.irq_pending(irq_pending), .core_ale(core_ale),
		.core_program_store_strobe(core_program_store_strobe)
	);
	initial forever #2.5 clock = ~clock;
	task automatic check(string n, logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(logic w, logic [7:0] d, logic [11:0] a = PA);
		@(posedge clock);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, 24'h0, d};
		@(posedge clock);
		penable <= '1;
		do @(posedge clock); while (pready !== '1);
		rd = prdata;
		se = pslverr;
		{psel, penable} <= '0;
	endtask
	task automatic go(logic [7:0] a, g, logic [1:0] m);
		apb('1, a);
		apb('1, g);
		@(negedge clock);
		check("mode", {in_power_down, in_idle}, m);
	endtask
	task automatic do_reset;
		@(posedge clock);
		rst_b <= '0;
		repeat (12) @(posedge clock);
		rst_b <= '1;
		@(negedge clock);
	endtask
	task automatic t_idle;
		go(8'h8d, 8'hac, 2'h1);
		check("gates", {osc_en, periph_clk_en, cpu_clk_en, wdt_clk_en}, 4'hc);
		check("strobes", {ale, program_store_strobe, clock_output_pin},
			3'h7);
		apb('0, 8'h0);
		check("read", rd, 32'h8c);
		@(posedge clock);
		wake <= '1;
		repeat (2) @(posedge clock);
		wake <= '0;
		@(negedge clock);
		check("woken", {in_idle, cpu_clk_en, wdt_clk_en}, 3'h3);
		go(8'h81, 8'ha0, 2'h1);
		do_reset;
		check("reset", {in_idle, cpu_clk_en, baud_double}, 3'h2);
	endtask
	task automatic t_refuse;
		for (int i = 0; i < 2; i++) begin
			go(8'h21 << i, 8'h20 << i, 2'h0);
			@(posedge clock);
			power_save_enable_pin_n <= '1;
			go(8'h01 << i, 8'h20 << i, 2'h0);
			@(posedge clock);
			power_save_enable_pin_n <= '0;
			apb('1, 8'h01 << i);
			@(posedge clock);
			retire_req <= '1;
			@(posedge clock);
			retire_req <= '0;
			apb('1, 8'h20 << i);
			@(negedge clock);
			check("lost arm", {in_power_down, in_idle}, 2'h0);
		end
	endtask
	task automatic t_pd;
		go(8'h8f, 8'hec, 2'h2);
		check("stopped", {osc_en, periph_clk_en, cpu_clk_en}, 3'h0);
		check("pins", {ale, program_store_strobe, clock_output_pin, alt_out},
			11'h0a5);
		@(posedge clock);
		{alt_out_in, wake} <= {8'h5a, 1'h1};
		repeat (4) @(posedge clock);
		wake <= '0;
		@(negedge clock);
		check("held", {in_power_down, alt_out}, 9'h1a5);
		do_reset;
		check("restart", {in_power_down, osc_en}, 2'h1);
		apb('0, 8'h0);
		check("reg reset", rd, {24'h0, psm_pkg::CTRL_RST});
		apb('0, 8'h0, 12'hffc);
		check("unmapped", se, 1'h1);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		do_reset;
		t_idle;
		t_refuse;
		t_pd;
		results;
	end
	initial begin
		#20000;
		err_count++;
		results;
	end
endmodule
